// *** shared/asc_pkg.sv ***
package asc_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CFG2     = 6'h09;
  localparam logic [5:0] IDX_CH1      = 6'h0B;
  localparam logic [5:0] IDX_CH2      = 6'h0C;
  localparam logic [5:0] IDX_CTRL     = 6'h10;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h11;
  localparam logic [5:0] IDX_IRQ_CLR  = 6'h12;
  localparam logic [5:0] IDX_IRQ_EN   = 6'h13;
  localparam logic [5:0] IDX_STATE    = 6'h14;

  // serial_bus_config_two fields
  localparam int unsigned CFG2_CHAIN_BIT  = 7;
  localparam int unsigned CFG2_ERRDIS_BIT = 5;
  localparam int unsigned CFG2_RESDIS_BIT = 4;
  localparam logic [7:0]  CFG2_WMASK      = 8'hB0;
  localparam logic [7:0]  CFG2_RST        = 8'h00;

  // channel slot route fields
  localparam int unsigned CH_PIN_BIT  = 6;
  localparam logic [7:0]  CH_WMASK    = 8'h7F;
  localparam logic [7:0]  CH1_RST     = 8'h00;
  localparam logic [7:0]  CH2_RST     = 8'h01;

  // framing control fields
  localparam int unsigned CTRL_FMT_LSB  = 0;
  localparam int unsigned CTRL_FILL_BIT = 2;
  localparam logic [7:0]  CTRL_WMASK    = 8'h07;
  localparam logic [7:0]  CTRL_RST      = 8'h00;

  // interrupt layout
  localparam int unsigned IRQ_ERR_BIT    = 0;
  localparam int unsigned IRQ_RESUME_BIT = 1;
  localparam logic [1:0]  IRQ_RST        = 2'h0;

  // serial timing counts, in bit-clock cycles
  localparam int unsigned SLOT_BITS = 32;
  localparam logic [11:0] FRAME_MAX = 12'hFFF;

  typedef enum logic [1:0] {
    ASC_FMT_TDM,
    ASC_FMT_I2S,
    ASC_FMT_LJ
  } asc_fmt_t;

  function automatic logic [7:0] regAddr(input logic [5:0] idx);
    regAddr = {idx, 2'b00};
  endfunction

endpackage

// *** src/asc_slot_config.sv ***
`timescale 1ns/1ps
// Functional notes
// - topology bit set chains devices; cleared means one shared serial bus.
// - bus errors are watched while check-disable bit is cleared, ignored when set.
// - resume bit clear restarts after error; set stays down until reprogrammed.
// - channel one pin bit picks primary output or general-purpose secondary pin.
// - in TDM, slot field n places the sample in time slot n.
// - in I2S/LJ, values 0-31 pick left slots, 32-63 pick right slots.
// - after reset channel one slot is zero and primary pin is selected.
// - unused bit-clock cycles drive zero or high impedance per fill setting.
module asc_slot_config (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        bitClk,
  input  wire logic        frameSync,
  input  wire logic        chainIn,
  input  wire logic [31:0] chanOneSample,
  input  wire logic [31:0] chanTwoSample,
  output logic             primarySerialOut,
  output logic             primarySerialOutEnN,
  output logic             generalPinOne,
  output logic             generalPinOneEnN,
  output logic             busErrorFlag,
  output logic             irq
);
  import asc_pkg::*;

  logic [7:0]  cfg2_reg;
  logic [7:0]  ch1_reg;
  logic [7:0]  ch2_reg;
  logic [7:0]  ctrl_reg;
  logic [1:0]  irqStat_reg;
  logic [1:0]  irqEn_reg;
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic [2:0]  bclkSync_reg;
  logic [2:0]  fsSync_reg;
  logic [1:0]  chainSync_reg;
  logic        fsPrev_reg;
  logic        rightHalf_reg;
  logic [10:0] bitCnt_reg;
  logic [11:0] frameCnt_reg;
  logic [11:0] lastLen_reg;
  logic        lastLenValid_reg;
  logic        frameSeen_reg;
  logic        errActive_reg;
  logic        halted_reg;
  logic        chainBit_reg;
  logic [31:0] ch1Sample_reg;
  logic [31:0] ch2Sample_reg;
  logic        primOut_reg;
  logic        primEnN_reg;
  logic        secOut_reg;
  logic        secEnN_reg;
  logic        irq_reg;

  // in I2S/LJ the top slot bit picks the half, the low five bits the slot
  function automatic logic slotHit(input asc_fmt_t fmt, input logic [5:0] slot,
                                   input logic [10:0] cnt, input logic right);
    case (fmt)
      ASC_FMT_I2S, ASC_FMT_LJ: slotHit = !cnt[10] && (right == slot[5])
                                         && (cnt[9:5] == slot[4:0]);
      default:                 slotHit = (cnt[10:5] == slot);
    endcase
  endfunction

  // bus decode
  wire        apbSetup  = psel & ~penable;
  wire        wrEn      = psel & penable & pwrite & pready_reg;
  wire        hitCfg2   = (paddr == regAddr(IDX_CFG2));
  wire        hitCh1    = (paddr == regAddr(IDX_CH1));
  wire        hitCh2    = (paddr == regAddr(IDX_CH2));
  wire        hitCtrl   = (paddr == regAddr(IDX_CTRL));
  wire        hitStat   = (paddr == regAddr(IDX_IRQ_STAT));
  wire        hitClr    = (paddr == regAddr(IDX_IRQ_CLR));
  wire        hitEn     = (paddr == regAddr(IDX_IRQ_EN));
  wire        hitState  = (paddr == regAddr(IDX_STATE));
  wire        hitAny    = hitCfg2 | hitCh1 | hitCh2 | hitCtrl | hitStat | hitClr
                          | hitEn | hitState;
  wire        cfgWrite  = wrEn & (hitCfg2 | hitCh1 | hitCh2 | hitCtrl);
  wire [7:0]  stateBits = {5'h00, lastLenValid_reg, halted_reg, errActive_reg};

  // read mux; the clear register is write-only and reads zero
  wire [7:0]  rdByte = hitCfg2  ? cfg2_reg :
                       hitCh1   ? ch1_reg :
                       hitCh2   ? ch2_reg :
                       hitCtrl  ? ctrl_reg :
                       hitStat  ? {6'h00, irqStat_reg} :
                       hitEn    ? {6'h00, irqEn_reg} :
                       hitState ? stateBits : 8'h00;

  // configuration fields
  wire        chainMode = cfg2_reg[CFG2_CHAIN_BIT];
  wire        errChkDis = cfg2_reg[CFG2_ERRDIS_BIT];
  wire        resumeDis = cfg2_reg[CFG2_RESDIS_BIT];
  wire        fillHiZ   = ctrl_reg[CTRL_FILL_BIT];
  wire        ch1Pin    = ch1_reg[CH_PIN_BIT];
  wire        ch2Pin    = ch2_reg[CH_PIN_BIT];
  wire asc_fmt_t fmt    = asc_fmt_t'(ctrl_reg[CTRL_FMT_LSB +: 2]);

  // link edges, seen only on the second synchroniser stage onward
  wire        bclkRise  = bclkSync_reg[1] & ~bclkSync_reg[2];
  wire        bclkFall  = ~bclkSync_reg[1] & bclkSync_reg[2];
  wire        fsLevel   = fsSync_reg[1];
  wire        fsRose    = bclkRise & fsLevel & ~fsPrev_reg;
  wire        fsFell    = bclkRise & ~fsLevel & fsPrev_reg;
  wire        isTdm     = (fmt != ASC_FMT_I2S) && (fmt != ASC_FMT_LJ);
  wire        frameStart = (fmt == ASC_FMT_I2S) ? fsFell : fsRose;
  wire        halfStart  = isTdm ? fsRose : (fsRose | fsFell);
  wire        rightNext  = (fmt == ASC_FMT_I2S) ? fsLevel : ~fsLevel;

  // error checks: frame length change or a missing frame sync
  wire        lenBad    = frameStart & lastLenValid_reg & (frameCnt_reg != lastLen_reg);
  wire        overrun   = bclkRise & ~frameStart & (frameCnt_reg == FRAME_MAX);
  wire        errDetect = ~errChkDis & (lenBad | overrun);
  wire        goodFrame = frameStart & lastLenValid_reg & (frameCnt_reg == lastLen_reg);
  wire        resumeEvt = goodFrame & errActive_reg & ~errDetect;
  wire        runOk     = ~errActive_reg & ~halted_reg;

  // slot selection per channel and pin
  wire        ch1Hit    = slotHit(fmt, ch1_reg[5:0], bitCnt_reg, rightHalf_reg);
  wire        ch2Hit    = slotHit(fmt, ch2_reg[5:0], bitCnt_reg, rightHalf_reg);
  wire [4:0]  bitSel    = ~bitCnt_reg[4:0]; // msb first within a slot
  wire        ch1Bit    = ch1Sample_reg[bitSel];
  wire        ch2Bit    = ch2Sample_reg[bitSel];
  wire        p1        = runOk & ch1Hit & ~ch1Pin;
  wire        p2        = runOk & ch2Hit & ~ch2Pin;
  wire        s1        = runOk & ch1Hit & ch1Pin;
  wire        s2        = runOk & ch2Hit & ch2Pin;
  wire        pass      = runOk & chainMode & ~p1 & ~p2;
  wire        primNext  = p1 ? ch1Bit : p2 ? ch2Bit : pass ? chainBit_reg : 1'b0;
  wire        primEnNx  = (p1 | p2 | pass) ? 1'b0 : fillHiZ;
  wire        secNext   = s1 ? ch1Bit : s2 ? ch2Bit : 1'b0;
  wire        secEnNx   = (s1 | s2) ? 1'b0 : fillHiZ;

  wire [1:0]  clrMask   = (wrEn & hitClr) ? pwdata[1:0] : 2'h0;
  wire [1:0]  irqEvt    = {resumeEvt, errDetect};

  // apb slave: one wait-free access, answer prepared in the setup cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= apbSetup;
      prdata_reg  <= apbSetup ? {24'h00_0000, rdByte} : prdata_reg;
      pslverr_reg <= apbSetup & ~hitAny;
    end
  end

  // configuration registers; reserved bits are masked to zero on write
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg2_reg  <= CFG2_RST;
      ch1_reg   <= CH1_RST;
      ch2_reg   <= CH2_RST;
      ctrl_reg  <= CTRL_RST;
      irqEn_reg <= IRQ_RST;
    end else if (wrEn) begin
      if (hitCfg2) cfg2_reg <= pwdata[7:0] & CFG2_WMASK;
      if (hitCh1) ch1_reg <= pwdata[7:0] & CH_WMASK;
      if (hitCh2) ch2_reg <= pwdata[7:0] & CH_WMASK;
      if (hitCtrl) ctrl_reg <= pwdata[7:0] & CTRL_WMASK;
      if (hitEn) irqEn_reg <= pwdata[1:0];
    end
  end

  // sticky events: a new event beats a clear in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqStat_reg <= IRQ_RST;
      irq_reg     <= 1'b0;
    end else begin
      irqStat_reg <= (irqStat_reg & ~clrMask) | irqEvt;
      irq_reg     <= |(irqStat_reg & irqEn_reg);
    end
  end

  // synchronisers for the link pins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bclkSync_reg  <= 3'h0;
      fsSync_reg    <= 3'h0;
      chainSync_reg <= 2'h0;
    end else begin
      bclkSync_reg  <= {bclkSync_reg[1:0], bitClk};
      fsSync_reg    <= {fsSync_reg[1:0], frameSync};
      chainSync_reg <= {chainSync_reg[0], chainIn};
    end
  end

  // framing counters on bit-clock rising edges; counts saturate, not wrap
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fsPrev_reg       <= 1'b0;
      rightHalf_reg    <= 1'b0;
      bitCnt_reg       <= 11'h7FF;
      frameCnt_reg     <= 12'h000;
      lastLen_reg      <= 12'h000;
      lastLenValid_reg <= 1'b0;
      frameSeen_reg    <= 1'b0;
      chainBit_reg     <= 1'b0;
    end else if (bclkRise) begin
      fsPrev_reg   <= fsLevel;
      chainBit_reg <= chainSync_reg[1];
      if (halfStart) begin
        bitCnt_reg    <= 11'h000;
        rightHalf_reg <= ~isTdm & rightNext;
      end else if (bitCnt_reg != 11'h7FF) begin
        bitCnt_reg <= bitCnt_reg + 11'h001;
      end
      if (frameStart) begin
        frameCnt_reg     <= 12'h001;
        lastLen_reg      <= frameCnt_reg;
        frameSeen_reg    <= 1'b1;
        // the part frame before the first sync is never learned as a length
        lastLenValid_reg <= frameSeen_reg && (frameCnt_reg != FRAME_MAX);
      end else if (frameCnt_reg != FRAME_MAX) begin
        frameCnt_reg <= frameCnt_reg + 12'h001;
      end
    end
  end

  // error and power-down state; a fresh error beats a clearing frame
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      errActive_reg <= 1'b0;
      halted_reg    <= 1'b0;
    end else begin
      errActive_reg <= errDetect | (errActive_reg & ~goodFrame);
      halted_reg    <= (errDetect & resumeDis) | (halted_reg & ~cfgWrite);
    end
  end

  // samples are taken once per frame so a slot never mixes two words
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ch1Sample_reg <= 32'h0000_0000;
      ch2Sample_reg <= 32'h0000_0000;
    end else if (frameStart) begin
      ch1Sample_reg <= chanOneSample;
      ch2Sample_reg <= chanTwoSample;
    end
  end

  // pins change on bit-clock falling edges for the host to sample on rising
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      primOut_reg <= 1'b0;
      primEnN_reg <= 1'b1;
      secOut_reg  <= 1'b0;
      secEnN_reg  <= 1'b1;
    end else if (bclkFall) begin
      primOut_reg <= primNext;
      primEnN_reg <= primEnNx;
      secOut_reg  <= secNext;
      secEnN_reg  <= secEnNx;
    end
  end

  assign pready              = pready_reg;
  assign prdata              = prdata_reg;
  assign pslverr             = pslverr_reg;
  assign primarySerialOut    = primOut_reg;
  assign primarySerialOutEnN = primEnN_reg;
  assign generalPinOne       = secOut_reg;
  assign generalPinOneEnN    = secEnN_reg;
  assign busErrorFlag        = errActive_reg;
  assign irq                 = irq_reg;

  // checks
  sequence s_prim_ch1;
    bclkFall && p1;
  endsequence

  sequence s_idle_fill;
    bclkFall && !p1 && !p2 && !pass && fillHiZ;
  endsequence

  property p_reset_route;
    @(posedge clk) $fell(sys_rst) |-> (ch1_reg[5:0] == 6'h00) && !ch1_reg[CH_PIN_BIT];
  endproperty
  a_reset_route: assert property (p_reset_route) else $error("ch1 route not reset");

  property p_reserved_zero;
    @(posedge clk) disable iff (sys_rst)
      !cfg2_reg[6] && (cfg2_reg[3:0] == 4'h0) && !ch1_reg[7] && !ch2_reg[7];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_no_err_when_off;
    @(posedge clk) disable iff (sys_rst) errChkDis && !errActive_reg |=> !errActive_reg;
  endproperty
  a_no_err_when_off: assert property (p_no_err_when_off) else $error("error while off");

  property p_prim_ch1;
    @(posedge clk) disable iff (sys_rst)
      s_prim_ch1 |=> !primarySerialOutEnN && (primarySerialOut == $past(ch1Bit));
  endproperty
  a_prim_ch1: assert property (p_prim_ch1) else $error("ch1 primary bit wrong");

  property p_sec_ch1;
    @(posedge clk) disable iff (sys_rst)
      bclkFall && s1 |=> !generalPinOneEnN && (generalPinOne == $past(ch1Bit));
  endproperty
  a_sec_ch1: assert property (p_sec_ch1) else $error("ch1 secondary bit wrong");

  property p_tdm_slot;
    @(posedge clk) disable iff (sys_rst)
      isTdm && (bitCnt_reg[10:5] == ch1_reg[5:0]) |-> ch1Hit;
  endproperty
  a_tdm_slot: assert property (p_tdm_slot) else $error("tdm slot missed");

  property p_half_slot;
    @(posedge clk) disable iff (sys_rst)
      !isTdm && ch1Hit |-> (rightHalf_reg == ch1_reg[5]) && !bitCnt_reg[10];
  endproperty
  a_half_slot: assert property (p_half_slot) else $error("half slot wrong");

  property p_idle_fill;
    @(posedge clk) disable iff (sys_rst) s_idle_fill |=> primarySerialOutEnN;
  endproperty
  a_idle_fill: assert property (p_idle_fill) else $error("idle cycle driven");

  property p_chain_pass;
    @(posedge clk) disable iff (sys_rst)
      bclkFall && pass |=> !primarySerialOutEnN && (primarySerialOut == $past(chainBit_reg));
  endproperty
  a_chain_pass: assert property (p_chain_pass) else $error("chain data lost");

  property p_err_mutes;
    @(posedge clk) disable iff (sys_rst)
      errActive_reg && bclkFall && !fillHiZ |=> !primarySerialOut && !generalPinOne;
  endproperty
  a_err_mutes: assert property (p_err_mutes) else $error("data during error");

  property p_halt_hold;
    @(posedge clk) disable iff (sys_rst) errDetect && resumeDis |=> halted_reg ##1 busErrorFlag;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("no power-down hold");

  property p_auto_resume;
    @(posedge clk) disable iff (sys_rst)
      resumeEvt && !halted_reg && !(errDetect && resumeDis) |=> runOk;
  endproperty
  a_auto_resume: assert property (p_auto_resume) else $error("no auto resume");

  property p_apb_ready;
    @(posedge clk) disable iff (sys_rst) apbSetup |=> pready ##1 !pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("pready timing wrong");

endmodule

// *** dv/asc_link_host.sv ***
`timescale 1ns/1ps
// far side: makes the link bit clock and frame sync, captures both data pins
module asc_link_host #(
  parameter int FB = 64
) (
  input  wire logic [1:0]  fmtSel,
  input  wire logic [3:0]  shortReq,
  input  wire logic [31:0] chainPat,
  input  wire logic        priOut,
  input  wire logic        priEnN,
  input  wire logic        secOut,
  input  wire logic        secEnN,
  output logic             bitClk,
  output logic             frameSync,
  output logic             chainIn,
  output logic             frameDone,
  output logic [4*FB-1:0]  capBits
);
  int              pos;
  int              len;
  int              prevLen;
  int              i;
  logic [3:0]      shortDone;
  logic [4*FB-1:0] work;
  // sync level: tdm pulse at start, i2s low on left half, lj high on left half
  function automatic logic fsLevel(input int p, input int l);
    case (fmtSel)
      2'd1: fsLevel = (p >= l / 2);
      2'd2: fsLevel = (p < l / 2);
      default: fsLevel = (p == 0);
    endcase
  endfunction
  // frames run back to back so the clock never idles; a short frame is a length fault
  initial begin
    bitClk = 1'b0;
    frameSync = 1'b1;
    chainIn = 1'b0;
    frameDone = 1'b0;
    capBits = '0;
    work = '0;
    shortDone = 4'h0;
    prevLen = FB;
    #7;
    forever begin
      len = (shortReq != shortDone) ? FB - 32 : FB;
      shortDone = shortReq;
      for (pos = 0; pos < len; pos++) begin
        bitClk = 1'b1;
        // the bit launched on the last fall has settled by this rise
        i = (pos == 0) ? prevLen - 1 : pos - 1;
        work[3*FB+i] = priOut & ~priEnN;
        work[2*FB+i] = priEnN;
        work[FB+i] = secOut & ~secEnN;
        work[i] = secEnN;
        if (pos == 0) begin
          capBits = work;
          frameDone = ~frameDone;
        end
        #32;
        bitClk = 1'b0;
        frameSync = fsLevel((pos + 1) % len, len);
        chainIn = chainPat[31 - (pos + 1) % 32];
        #32;
      end
      prevLen = len;
    end
  end
endmodule

// *** dv/asc_slot_config_tb.sv ***
`timescale 1ns/1ps
// self-checking bench: apb master, link partner and a reference frame model
module asc_slot_config_tb;
  import asc_pkg::*;
  localparam int FB = 64;
  logic            clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]      paddr, cfg2, ch1, ch2, ctrl;
  logic [31:0]     pwdata, prdata, s1, s2, chainPat, rd;
  logic            bitClk, frameSync, chainIn, priOut, priEnN, secOut, secEnN;
  logic            busErrorFlag, irq, frameDone;
  logic [1:0]      fmtSel;
  logic [3:0]      shortReq;
  logic [4*FB-1:0] capBits;
  int              error_cnt, comparisons, seed, cycles, i;
  asc_slot_config asc_slot_config_inst (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .bitClk(bitClk), .frameSync(frameSync), .chainIn(chainIn), .chanOneSample(s1),
    .chanTwoSample(s2), .primarySerialOut(priOut), .primarySerialOutEnN(priEnN),
    .generalPinOne(secOut), .generalPinOneEnN(secEnN), .busErrorFlag(busErrorFlag),
    .irq(irq));
  asc_link_host #(.FB(FB)) asc_link_host_inst (
    .fmtSel(fmtSel), .shortReq(shortReq), .chainPat(chainPat), .priOut(priOut),
    .priEnN(priEnN), .secOut(secOut), .secEnN(secEnN), .bitClk(bitClk),
    .frameSync(frameSync), .chainIn(chainIn), .frameDone(frameDone), .capBits(capBits));
  // 200 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // hang guard, well above the planned run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_frame(input logic [4*FB-1:0] got, input logic [4*FB-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen high; no latency assumed
  task automatic apb(input logic [5:0] idx, input logic wr, input logic [7:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [5:0] idx, input logic [7:0] mask, input logic [7:0] exp);
    apb(idx, 1'b0, 8'h00);
    chk_val(rd & {24'hFF_FFFF, mask}, {24'h0, exp});
  endtask
  task automatic waitf(input int n);
    repeat (n) @(frameDone);
  endtask
  // reference frame: slot hits per pin, ch1 over ch2, chain or fill elsewhere
  function automatic logic [4*FB-1:0] expFrame(input logic stopped);
    logic [4*FB-1:0] e;
    logic [7:0]      r;
    logic [31:0]     d;
    logic            used;
    int              p, k, sv, g;
    e = '0;
    for (p = 0; p < FB; p++) begin
      sv = (ctrl[1:0] inside {2'd1, 2'd2}) ? (p / (FB / 2)) * 32 + (p % (FB / 2)) / 32 : p / 32;
      e[2*FB+p] = ctrl[2];
      e[p] = ctrl[2];
      used = 1'b0;
      for (k = 0; k < 2; k++) begin
        r = k ? ch1 : ch2;
        d = k ? s1 : s2;
        g = r[6] ? 0 : 2;
        if (!stopped && r[5:0] == sv) begin
          e[(g+1)*FB+p] = d[31 - p % 32];
          e[g*FB+p] = 1'b0;
          used = used | !r[6];
        end
      end
      if (cfg2[7] && !used && !stopped) begin
        e[3*FB+p] = chainPat[31 - p % 32];
        e[2*FB+p] = 1'b0;
      end
    end
    return e;
  endfunction
  // random routing in one format; shared slots exercise channel priority
  task automatic run_cfg(input logic [1:0] fmt, input logic daisy);
    logic [31:0] rv;
    @(posedge clk);
    s1 <= $random(seed);
    s2 <= $random(seed);
    chainPat <= $random(seed);
    rv = $random(seed);
    ch1 = rv[7:0] & 8'h61;
    ch2 = rv[15:8] & 8'h61;
    ctrl = {5'h00, rv[16], fmt};
    cfg2 = daisy ? 8'h80 : 8'h00;
    wr(IDX_CTRL, ctrl);
    wr(IDX_CFG2, cfg2);
    wr(IDX_CH1, ch1);
    wr(IDX_CH2, ch2);
    fmtSel <= fmt;
    rdchk(IDX_CH1, 8'hFF, ch1);
    waitf(5);
    chk_frame(capBits, expFrame(1'b0));
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d);
  endtask
  task automatic fault_frame();
    shortReq <= shortReq + 4'h1;
    waitf(2);
    repeat (100) @(posedge clk);
  endtask
  initial begin
    seed = 42;
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    fmtSel = 2'd0;
    shortReq = 4'h0;
    s1 = $random(seed);
    s2 = $random(seed);
    chainPat = 32'h0;
    {cfg2, ch1, ch2, ctrl} = 32'h0000_0100;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rdchk(IDX_CFG2, 8'hFF, 8'h00);
    rdchk(IDX_CH1, 8'hFF, 8'h00);
    rdchk(IDX_CH2, 8'hFF, 8'h01);
    apb(6'h3F, 1'b0, 8'h00);
    chk_val({31'h0, err}, 32'h1);
    chk_val(rd, 32'h0);
    waitf(4);
    chk_frame(capBits, expFrame(1'b0));
    rdchk(IDX_IRQ_STAT, 8'hFF, 8'h00);
    for (i = 0; i < 8; i++) run_cfg(2'(i / 2), 1'b0);
    run_cfg(2'd0, 1'b1);
    // length fault: flag, sticky status and level irq, then automatic resume
    ctrl = 8'h04;
    cfg2 = 8'h00;
    wr(IDX_CTRL, ctrl);
    wr(IDX_CFG2, cfg2);
    wr(IDX_IRQ_CLR, 8'h03);
    wr(IDX_IRQ_EN, 8'h01);
    fault_frame();
    chk_val({31'h0, busErrorFlag}, 32'h1);
    chk_val({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_EN, 8'h00);
    repeat (2) @(posedge clk);
    chk_val({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_EN, 8'h03);
    waitf(4);
    chk_val({31'h0, busErrorFlag}, 32'h0);
    rdchk(IDX_IRQ_STAT, 8'hFF, 8'h03);
    chk_frame(capBits, expFrame(1'b0));
    wr(IDX_IRQ_CLR, 8'h03);
    rdchk(IDX_IRQ_STAT, 8'hFF, 8'h00);
    chk_val({31'h0, irq}, 32'h0);
    // detection switched off: the same fault goes unseen
    cfg2 = 8'h20;
    wr(IDX_CFG2, cfg2);
    fault_frame();
    chk_val({31'h0, busErrorFlag}, 32'h0);
    waitf(3);
    rdchk(IDX_IRQ_STAT, 8'hFF, 8'h00);
    // resume disabled: stays halted with pins at fill until reprogrammed
    cfg2 = 8'h10;
    wr(IDX_CFG2, cfg2);
    fault_frame();
    waitf(3);
    rdchk(IDX_STATE, 8'h02, 8'h02);
    chk_frame(capBits, expFrame(1'b1));
    cfg2 = 8'h00;
    wr(IDX_CFG2, cfg2);
    rdchk(IDX_STATE, 8'h02, 8'h00);
    waitf(3);
    chk_frame(capBits, expFrame(1'b0));
    end_sim();
  end
endmodule
